// File: hw/spwp_map.vh
/*
 Constants for the serial peripheral word port: word length and
 synchroniser depth. Assumes inclusion by bare name from the design files.
*/
`ifndef SPWP_MAP_VH
`define SPWP_MAP_VH
`define SPWP_WORD_BITS 16
`define SPWP_CNT_W 5
`define SPWP_RESET_WORD 16'h0000
`define SPWP_SYNC_STAGES 2
// Idle levels of {shift clock, select, host data}: select idles high
`define SPWP_PIN_IDLE 3'h2
`endif

// File: hw/spwp_sync.v
/*
 Two-flop level synchroniser, one per bit of a vector, each bit reset
 to its idle level. Assumes inputs are asynchronous to clk_i; output lags
 by two edges.
*/
`timescale 1ns/1ps
module spwp_sync #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire clk_i,                // Core clock
    input wire resetn_i,             // Async reset, active low
    input wire [WIDTH-1:0] async_i,  // Asynchronous levels
    output wire [WIDTH-1:0] sync_o   // Synchronised levels
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_bit
            reg meta_q;
            reg sync_q;
            always @(posedge clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                begin
                    // Idle level avoids a false edge after reset
                    meta_q <= RST_VAL[g];
                    sync_q <= RST_VAL[g];
                end
                else
                begin
                    meta_q <= async_i[g];
                    sync_q <= meta_q;
                end
            end
            assign sync_o[g] = sync_q;
        end
    endgenerate
endmodule // spwp_sync

// File: hw/spwp_port.v
/*
 Serial peripheral word port, device end. The host drives the shift
 clock, chip select and host-to-device line; all are sampled by core_clk_i.
 Assumes the core clock is at least eight times the shift clock rate.
*/
// Operation
// RULE1: shift clock and host line are inputs
// RULE2: shift in and out together, one bit/period
// RULE3: launch next output bit after falling edge
// RULE4: capture host bit on rising edge
// RULE5: host waits two periods after select low
// RULE6: host frames each 16-bit word with select
// RULE7: ignore clock while deselected; restart on select
`timescale 1ns/1ps
`include "spwp_map.vh"
module spwp_port #(
    parameter WORD_BITS = `SPWP_WORD_BITS
) (
    input wire core_clk_i,                  // Core clock, 25 MHz
    input wire resetn_i,                    // Async reset, active low
    input wire serial_shift_clock_i,        // Shift clock from host
    input wire chip_select_n_i,             // Chip select, active low
    input wire host_to_dev_line_i,          // Serial data from host
    output reg dev_to_host_line_o,          // Serial data to host
    input wire [WORD_BITS-1:0] tx_word_i,   // Word returned next frame
    output reg tx_take_o,                   // Pulse: tx_word_i loaded
    output reg [WORD_BITS-1:0] rx_word_o,   // Last word received
    output reg rx_valid_o,                  // Pulse: rx_word_o new
    output reg busy_o                       // Chip select active
);
    localparam [1:0] ST_IDLE = 2'b00;   // Deselected, clock edges ignored
    localparam [1:0] ST_SHIFT = 2'b01;  // Word in progress
    localparam [1:0] ST_FULL = 2'b10;   // Word complete, extra edges dropped

    wire [2:0] pins_s;
    wire sck_s;
    wire cs_n_s;
    wire simo_s;
    wire sck_rise;
    wire sck_fall;
    wire cs_fall;
    wire rx_shift_en;
    wire tx_shift_en;
    wire last_bit;
    reg sck_q;
    reg cs_n_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [`SPWP_CNT_W-1:0] cnt_q;
    reg [`SPWP_CNT_W-1:0] cnt_d;
    reg [WORD_BITS-1:0] rx_sh_q;
    reg [WORD_BITS-1:0] rx_sh_d;
    reg [WORD_BITS-1:0] tx_sh_q;
    reg [WORD_BITS-1:0] tx_sh_d;
    reg line_d;

    // All host pins cross through two flops before use; idle levels
    // preload the flops so release of reset shows no false select edge
    spwp_sync #(
        .WIDTH(3),
        .RST_VAL(`SPWP_PIN_IDLE)
    ) u_sync (
        .clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .async_i({serial_shift_clock_i, chip_select_n_i, host_to_dev_line_i}), // see RULE1
        .sync_o(pins_s)
    );

    assign sck_s = pins_s[2];
    assign cs_n_s = pins_s[1];
    assign simo_s = pins_s[0];
    assign sck_rise = sck_s & ~sck_q;
    assign sck_fall = ~sck_s & sck_q;
    assign cs_fall = ~cs_n_s & cs_n_q;
    // Shifting only while selected and inside the current word
    assign rx_shift_en = (state_q == ST_SHIFT) & ~cs_n_s & sck_rise; // see RULE7
    assign tx_shift_en = (state_q == ST_SHIFT) & ~cs_n_s & sck_fall & (cnt_q != 5'h00);
    assign last_bit = (cnt_q == WORD_BITS - 1);

    // Previous synchronised levels for edge detection
    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sck_q <= 1'b0;
            cs_n_q <= 1'b1;
        end
        else
        begin
            sck_q <= sck_s;
            cs_n_q <= cs_n_s;
        end
    end

    // Frame state: select low opens a word, the last rising edge closes it
    always @*
    begin
        state_d = state_q;
        if (cs_n_s)
        begin
            state_d = ST_IDLE; // see RULE7
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (cs_fall)
                    begin
                        state_d = ST_SHIFT;
                    end
                end
                ST_SHIFT:
                begin
                    if (sck_rise && last_bit)
                    begin
                        // Clocks past one word are dropped until reselect
                        state_d = ST_FULL; // see RULE6
                    end
                end
                ST_FULL:
                begin
                    state_d = ST_FULL;
                end
                default:
                begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always @*
    begin
        cnt_d = cnt_q;
        if (cs_fall)
        begin
            cnt_d = 5'h00; // see RULE7
        end
        else if (rx_shift_en)
        begin
            cnt_d = cnt_q + 5'h01; // see RULE2
        end
    end

    always @*
    begin
        rx_sh_d = rx_sh_q;
        if (rx_shift_en)
        begin
            rx_sh_d = {rx_sh_q[WORD_BITS-2:0], simo_s}; // see RULE4
        end
    end

    // The host's two-period lead leaves time to present the first bit
    always @*
    begin
        tx_sh_d = tx_sh_q;
        line_d = dev_to_host_line_o;
        if (cs_fall)
        begin
            tx_sh_d = tx_word_i; // see RULE5
            line_d = tx_word_i[WORD_BITS-1];
        end
        else if (tx_shift_en)
        begin
            tx_sh_d = {tx_sh_q[WORD_BITS-2:0], 1'b0};
            line_d = tx_sh_q[WORD_BITS-2]; // see RULE3
        end
    end

    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // Word output only changes on a completed word, so partial words vanish
    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rx_sh_q <= `SPWP_RESET_WORD;
            rx_word_o <= `SPWP_RESET_WORD;
            rx_valid_o <= 1'b0;
        end
        else
        begin
            rx_sh_q <= rx_sh_d;
            rx_valid_o <= rx_shift_en & last_bit;
            if (rx_shift_en && last_bit)
            begin
                rx_word_o <= rx_sh_d; // see RULE6
            end
        end
    end

    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tx_sh_q <= `SPWP_RESET_WORD;
            dev_to_host_line_o <= 1'b0;
            tx_take_o <= 1'b0;
        end
        else
        begin
            tx_sh_q <= tx_sh_d;
            dev_to_host_line_o <= line_d; // see RULE2
            tx_take_o <= cs_fall;
        end
    end

    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            busy_o <= 1'b0;
        end
        else
        begin
            busy_o <= ~cs_n_s;
        end
    end
endmodule // spwp_port

// File: sim/spwp_chk_sva.sv
/* Checker for spwp_port pins. Assumes bind into spwp_port. */
`timescale 1ns/1ps
module spwp_chk (
    input wire core_clk_i, // Clock
    input wire resetn_i, // Reset
    input wire serial_shift_clock_i, // Shift clock
    input wire chip_select_n_i, // Select
    input wire dev_to_host_line_o, // Data out
    input wire tx_take_o, // Load strobe
    input wire rx_valid_o, // Word strobe
    input wire busy_o // Frame active
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_hold; $rose(serial_shift_clock_i) |=> $stable(dev_to_host_line_o)[*3]; endproperty
    a_hold: assert property (p_hold) else $error("data moved near rise");
    property p_busy; $fell(chip_select_n_i) |-> ##[2:4] (busy_o && tx_take_o); endproperty
    a_busy: assert property (p_busy) else $error("no frame start");
    property p_idle; !busy_o |-> !rx_valid_o; endproperty
    a_idle: assert property (p_idle) else $error("word while idle");
    property p_pulse; rx_valid_o |=> !rx_valid_o; endproperty
    a_pulse: assert property (p_pulse) else $error("long strobe");
    property p_cap; rx_valid_o |-> serial_shift_clock_i; endproperty
    a_cap: assert property (p_cap) else $error("late word");
endmodule // spwp_chk
bind spwp_port spwp_chk u_spwp_chk (.core_clk_i, .resetn_i, .serial_shift_clock_i, .chip_select_n_i,
    .dev_to_host_line_o, .tx_take_o, .rx_valid_o, .busy_o);

// File: sim/spwp_host_model.sv
/* Host model, mode 0, 320 ns shift period. Assumes device answers per edge. */
`timescale 1ns/1ps
module spwp_host_model (
    output reg sclk_o = 1'b0, // Shift clock
    output reg cs_n_o = 1'b1, // Select
    output reg mosi_o = 1'b0, // Host data
    input wire miso_i // Device data
);
    task xfer(input [15:0] w, input integer n, output [15:0] r);
        integer i;
    begin
        r = 16'h0000;
        #7 cs_n_o = 1'b0;
        #640;
        for (i = 15; i > 15 - n; i = i - 1)
        begin
            mosi_o = w[i];
            #160 sclk_o = 1'b1;
            r[i] = miso_i;
            #160 sclk_o = 1'b0;
        end
        #40 mosi_o = ~mosi_o; // No stale bit after release
        #280 cs_n_o = 1'b1;
        #640;
    end
    endtask
    // Clocks with select high; the device must not count them
    task idle_clocks(input integer n);
        integer i;
    begin
        mosi_o = 1'b1;
        for (i = 0; i < n; i = i + 1)
        begin
            #160 sclk_o = 1'b1;
            #160 sclk_o = 1'b0;
        end
        #640;
    end
    endtask
endmodule // spwp_host_model

// File: sim/test_spwp_port.sv
/* Bench for spwp_port. Assumes spwp_host_model as host. */
`timescale 1ns/1ps
module test_spwp_port;
    reg core_clk_i = 1'b0;
    reg resetn_i = 1'b0;
    reg [15:0] tx_word_i = 16'h0000;
    reg [15:0] rx_last = 16'h0000;
    reg [15:0] got;
    wire sclk, cs_n, mosi, miso, take, rxv, busy;
    wire [15:0] rx_word;
    integer fail_count = 0;
    integer num_checks = 0;
    integer n_rx = 0;
    integer n_take = 0;
    integer cycles = 0;
    always #20 core_clk_i = ~core_clk_i;
    spwp_host_model u_spwp_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
    spwp_port u_spwp_port (.core_clk_i, .resetn_i, .serial_shift_clock_i(sclk), .chip_select_n_i(cs_n),
        .host_to_dev_line_i(mosi), .dev_to_host_line_o(miso), .tx_word_i, .tx_take_o(take),
        .rx_word_o(rx_word), .rx_valid_o(rxv), .busy_o(busy));
    task check(input [15:0] seen, input [15:0] exp, input [63:0] what);
    begin
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            fail_count = fail_count + 1;
            $display("wrong value %0s expected %h seen %h", what, exp, seen);
        end
    end
    endtask
    task final_report;
    begin
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    always @(posedge core_clk_i)
    begin
        cycles <= cycles + 1;
        if (rxv === 1'b1)
        begin
            rx_last <= rx_word;
            n_rx <= n_rx + 1;
        end
        if (take === 1'b1)
        begin
            n_take <= n_take + 1;
        end
        if (cycles == 2000)
        begin
            fail_count = fail_count + 1;
            final_report;
        end
    end
    task t_word;
    begin
        @(posedge core_clk_i);
        tx_word_i <= 16'hA5C3;
        u_spwp_host_model.xfer(16'h3C5A, 16, got);
        check(got, 16'hA5C3, "tx");
        check(rx_last, 16'h3C5A, "rx");
        check(n_rx[15:0], 16'h0001, "count");
        check({15'h0000, busy}, 16'h0000, "busy");
        check(n_take[15:0], 16'h0001, "take");
    end
    endtask
    task t_part;
    begin
        @(posedge core_clk_i);
        tx_word_i <= 16'h0F0F;
        u_spwp_host_model.xfer(16'hFFFF, 8, got);
        check(n_rx[15:0], 16'h0001, "partial");
        u_spwp_host_model.idle_clocks(16);
        check(n_rx[15:0], 16'h0001, "idle");
        u_spwp_host_model.xfer(16'h8001, 16, got);
        check(got, 16'h0F0F, "tx2");
        check(rx_last, 16'h8001, "rx2");
        check(n_take[15:0], 16'h0003, "takes");
    end
    endtask
    task t_reset;
    begin
        @(posedge core_clk_i);
        resetn_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        check(rx_word, 16'h0000, "rstword");
        check(n_take[15:0], 16'h0003, "rsttake");
        tx_word_i <= 16'h1234;
        u_spwp_host_model.xfer(16'hC001, 16, got);
        check(got, 16'h1234, "tx3");
        check(rx_last, 16'hC001, "rx3");
    end
    endtask
    initial
    begin
        repeat (3) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        t_word;
        t_part;
        t_reset;
        final_report;
    end
endmodule // test_spwp_port
